// ---- core/pgp_pkg.sv ----
// package of register map, field layout and reset values for the port 1 gpio block
package pgp_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam logic [15:0] OFF_DATA = 16'hFFD4;
	localparam logic [15:0] OFF_DIR = 16'hFFE4;
	localparam logic [15:0] OFF_PULLUP = 16'hFFED;
	localparam logic [15:0] OFF_FUNC = 16'hFFFC;
	// byte address is four times the register index, so it needs two more bits than the index
	localparam logic [17:0] BYTE_DATA = {OFF_DATA, 2'b00};
	localparam logic [17:0] BYTE_DIR = {OFF_DIR, 2'b00};
	localparam logic [17:0] BYTE_PULLUP = {OFF_PULLUP, 2'b00};
	localparam logic [17:0] BYTE_FUNC = {OFF_FUNC, 2'b00};
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_FUNC = 8'h04;
	localparam logic [7:0] PIN_MASK = 8'hF1;
	localparam logic [7:0] FUNC_FIXED = 8'h04;
	localparam logic [7:0] DIR_READ = 8'hFF;
	localparam int unsigned BIT_INT3 = 7;
	localparam int unsigned BIT_INT2 = 6;
	localparam int unsigned BIT_INT1 = 5;
	localparam int unsigned BIT_PWM = 4;
	localparam int unsigned BIT_TCLK = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/pgp_sync.sv ----
`timescale 1ns/1ps
// three-stage pin synchroniser; output changes once stages two and three agree
module pgp_sync
(
	input  wire logic MCLK_I,
	input  wire logic RST_N_I,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			level_o <= 1'b0;
		else if (s2_q == s3_q)
			level_o <= s3_q;
	end
endmodule // pgp_sync

// ---- core/pgp_port1.sv ----
`timescale 1ns/1ps
// port 1 gpio with pin function mux, axi4-lite register slave
// Functional notes
// - an output latch bit for pins 7..4 and 0 drives the pin when it is an output.
// - with direction 1 a data read returns the latched value.
// - with direction 0 a data read returns the synchronised pin level.
// - direction 1 makes the pin an output, 0 an input.
// - direction and latch drive the pin only while it is selected as general i/o; pull-up and data read use the raw direction bit.
// - the direction register is write-only and reads as all ones.
// - the pull-up is on only with direction 0 and pull-up enable 1.
// - reset clears latch, direction and pull-up enable to 0x00 and loads 0x04 into function select.
// - function select bits 3 and 1 read 0, bit 2 reads 1, writes to them do nothing.
// - function bit 7 at 1 makes pin 7 an input for interrupt 3 and timer trigger.
// - function bits 6 and 5 at 1 make pins 6 and 5 inputs to interrupts 2 and 1.
// - function bit 4 at 1 routes the pwm output onto pin 4.
// - function bit 0 at 1 drives pin 0 with the timer clock output.
// - latch and pull-up enable bits 3..1 read 0 and ignore writes.
// - every pull-up is off after reset.
module pgp_port1
	import pgp_pkg::*;
(
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [17:0] S_AWADDR_I,
	input  wire logic        S_AWVALID_I,
	output logic             S_AWREADY_O,
	input  wire logic [31:0] S_WDATA_I,
	input  wire logic [3:0]  S_WSTRB_I,
	input  wire logic        S_WVALID_I,
	output logic             S_WREADY_O,
	output logic [1:0]       S_BRESP_O,
	output logic             S_BVALID_O,
	input  wire logic        S_BREADY_I,
	input  wire logic [17:0] S_ARADDR_I,
	input  wire logic        S_ARVALID_I,
	output logic             S_ARREADY_O,
	output logic [31:0]      S_RDATA_O,
	output logic [1:0]       S_RRESP_O,
	output logic             S_RVALID_O,
	input  wire logic        S_RREADY_I,
	input  wire logic [7:0]  PIN_I,
	output logic [7:0]       PIN_O,
	output logic [7:0]       PIN_OE_N_O,
	output logic [7:0]       PULLUP_EN_O,
	input  wire logic        PWM_I,
	input  wire logic        TIMER_CLK_OUT_I,
	output logic             EXT_INT3_O,
	output logic             TIMER_TRIGGER_O,
	output logic             EXT_INT2_O,
	output logic             EXT_INT1_O
);
	logic [7:0]  out_latch_q;
	logic [7:0]  direction_q;
	logic [7:0]  pullup_q;
	logic [7:0]  func_q;
	logic [7:0]  pin_sync;
	logic [7:0]  gpio_sel;
	logic [7:0]  dir_eff;
	logic [7:0]  data_read;
	logic [17:0] awaddr_q;
	logic        aw_have_q;
	logic [31:0] wdata_q;
	logic        wstrb0_q;
	logic        w_have_q;
	logic        wr_fire;
	logic        ar_fire;
	logic [7:0]  rbyte;
	logic        rhit;
	logic        whit;

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_sync
			if (PIN_MASK[g])
			begin : g_on
				pgp_sync u_sync
				(
					.MCLK_I  (MCLK_I),
					.RST_N_I (RST_N_I),
					.pin_i   (PIN_I[g]),
					.level_o (pin_sync[g])
				);
			end
			else
			begin : g_off
				assign pin_sync[g] = 1'b0;
			end
		end
	endgenerate

	// write channel capture: address and data taken in either order
	assign S_AWREADY_O = !aw_have_q && !S_BVALID_O;
	assign S_WREADY_O  = !w_have_q && !S_BVALID_O;
	assign wr_fire     = aw_have_q && w_have_q && !S_BVALID_O;

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			aw_have_q <= 1'b0;
			awaddr_q  <= '0;
		end
		else if (S_AWVALID_I && S_AWREADY_O)
		begin
			aw_have_q <= 1'b1;
			awaddr_q  <= S_AWADDR_I;
		end
		else if (wr_fire)
			aw_have_q <= 1'b0;
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			w_have_q <= 1'b0;
			wdata_q  <= '0;
			wstrb0_q <= 1'b0;
		end
		else if (S_WVALID_I && S_WREADY_O)
		begin
			w_have_q <= 1'b1;
			wdata_q  <= S_WDATA_I;
			wstrb0_q <= S_WSTRB_I[0];
		end
		else if (wr_fire)
			w_have_q <= 1'b0;
	end

	// full address decode of aligned words
	always_comb
	begin
		whit = 1'b0;
		if (awaddr_q[1:0] == 2'h0)
		begin
			case (awaddr_q[17:2])
				OFF_DATA, OFF_DIR, OFF_PULLUP, OFF_FUNC: whit = 1'b1;
				default:                                 whit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			S_BVALID_O <= 1'b0;
			S_BRESP_O  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			S_BVALID_O <= 1'b1;
			S_BRESP_O  <= whit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_BREADY_I)
			S_BVALID_O <= 1'b0;
	end

	// register writes land on the edge that completes the bus write
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			out_latch_q <= RST_DATA;
			direction_q <= RST_DIR;
			pullup_q    <= RST_PULLUP;
			func_q      <= RST_FUNC;
		end
		else if (wr_fire && whit && wstrb0_q)
		begin
			case (awaddr_q[17:2])
				OFF_DATA:   out_latch_q <= wdata_q[7:0] & PIN_MASK;
				OFF_DIR:    direction_q <= wdata_q[7:0] & PIN_MASK;
				OFF_PULLUP: pullup_q    <= wdata_q[7:0] & PIN_MASK;
				OFF_FUNC:   func_q      <= (wdata_q[7:0] & PIN_MASK) | FUNC_FIXED;
				default:    func_q      <= func_q;
			endcase
		end
	end

	// pin mux: a set function bit takes the pin away from gpio
	assign gpio_sel = ~func_q & PIN_MASK;
	assign dir_eff  = direction_q & gpio_sel;

	always_comb
	begin
		PIN_O      = out_latch_q & PIN_MASK;
		PIN_OE_N_O = ~dir_eff;
		PIN_OE_N_O[BIT_INT3] = ~dir_eff[BIT_INT3];
		PIN_OE_N_O[BIT_INT2] = ~dir_eff[BIT_INT2];
		PIN_OE_N_O[BIT_INT1] = ~dir_eff[BIT_INT1];
		if (func_q[BIT_PWM])
		begin
			PIN_O[BIT_PWM]      = PWM_I;
			PIN_OE_N_O[BIT_PWM] = 1'b0;
		end
		if (func_q[BIT_TCLK])
		begin
			PIN_O[BIT_TCLK]      = TIMER_CLK_OUT_I;
			PIN_OE_N_O[BIT_TCLK] = 1'b0;
		end
	end

	// pull-up follows the raw direction bit, as the pull-up table does
	assign PULLUP_EN_O = pullup_q & ~direction_q & PIN_MASK;

	// interrupt inputs idle high and the timer trigger idles low when not selected, so unselected pins never fire interrupts
	assign EXT_INT3_O      = func_q[BIT_INT3] ? pin_sync[BIT_INT3] : 1'b1;
	assign TIMER_TRIGGER_O = func_q[BIT_INT3] ? pin_sync[BIT_INT3] : 1'b0;
	assign EXT_INT2_O      = func_q[BIT_INT2] ? pin_sync[BIT_INT2] : 1'b1;
	assign EXT_INT1_O      = func_q[BIT_INT1] ? pin_sync[BIT_INT1] : 1'b1;

	// data read: latch for outputs, pin level for inputs
	assign data_read = ((out_latch_q & direction_q) | (pin_sync & ~direction_q)) & PIN_MASK;

	always_comb
	begin
		rbyte = 8'h00;
		rhit  = 1'b0;
		if (S_ARADDR_I[1:0] == 2'h0)
		begin
			case (S_ARADDR_I[17:2])
				OFF_DATA:
				begin
					rbyte = data_read;
					rhit  = 1'b1;
				end
				OFF_DIR:
				begin
					rbyte = DIR_READ;
					rhit  = 1'b1;
				end
				OFF_PULLUP:
				begin
					rbyte = pullup_q;
					rhit  = 1'b1;
				end
				OFF_FUNC:
				begin
					rbyte = func_q;
					rhit  = 1'b1;
				end
				default:
				begin
					rbyte = 8'h00;
					rhit  = 1'b0;
				end
			endcase
		end
	end

	assign S_ARREADY_O = !S_RVALID_O;
	assign ar_fire     = S_ARVALID_I && S_ARREADY_O;

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			S_RVALID_O <= 1'b0;
			S_RDATA_O  <= '0;
			S_RRESP_O  <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			S_RVALID_O <= 1'b1;
			S_RDATA_O  <= {24'h000000, rbyte};
			S_RRESP_O  <= rhit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_RREADY_I)
			S_RVALID_O <= 1'b0;
	end

	AST_FUNC_FIXED: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(func_q & ~PIN_MASK) == FUNC_FIXED)
		else $error("function select fixed bits wrong");
	AST_LATCH_RSVD: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		((out_latch_q | pullup_q) & ~PIN_MASK) == 8'h00)
		else $error("reserved latch or pull-up bits set");
	AST_PULLUP: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		wr_fire && whit && wstrb0_q && awaddr_q[17:2] == OFF_DIR |=>
			(PULLUP_EN_O & $past(wdata_q[7:0])) == 8'h00)
		else $error("pull-up left on for an output pin");
	AST_DIR_READ: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		ar_fire && S_ARADDR_I == {OFF_DIR, 2'h0} |=> S_RDATA_O[7:0] == DIR_READ)
		else $error("direction read not all ones");
	AST_OUT_DRIVE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		gpio_sel[BIT_INT2] && direction_q[BIT_INT2] |-> !PIN_OE_N_O[BIT_INT2]
			&& PIN_O[BIT_INT2] == out_latch_q[BIT_INT2])
		else $error("gpio output not driven from latch");
	AST_ALT_INPUT: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		func_q[BIT_INT3] |-> PIN_OE_N_O[BIT_INT3] && EXT_INT3_O == pin_sync[BIT_INT3])
		else $error("alternate input pin driven");
	AST_PWM_ROUTE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		func_q[BIT_PWM] |-> !PIN_OE_N_O[BIT_PWM] && PIN_O[BIT_PWM] == PWM_I)
		else $error("pwm not on pin 4");
	AST_TCLK_ROUTE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		func_q[BIT_TCLK] |-> !PIN_OE_N_O[BIT_TCLK] && PIN_O[BIT_TCLK] == TIMER_CLK_OUT_I)
		else $error("timer clock not on pin 0");
	AST_WRITE_LAND: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		wr_fire && awaddr_q == {OFF_PULLUP, 2'h0} && wstrb0_q |=>
			pullup_q == ($past(wdata_q[7:0]) & PIN_MASK))
		else $error("pull-up write did not land");
	AST_READ_INPUT: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		ar_fire && S_ARADDR_I == {OFF_DATA, 2'h0} && !direction_q[BIT_INT1] |=>
			S_RDATA_O[BIT_INT1] == $past(pin_sync[BIT_INT1]))
		else $error("input read not pin level");

	COV_WRITE: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) wr_fire && whit);
	COV_READ: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) ar_fire && rhit);
	COV_PWM: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) func_q[BIT_PWM]);
	COV_PULL: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) PULLUP_EN_O != 8'h00);
endmodule // pgp_port1

// ---- dv/pgp_pin_model.sv ----
`timescale 1ns/1ps
// pin-side partner model: resolves each port pin level
module pgp_pin_model
(
	input  wire logic [7:0] pin_o_i,
	input  wire logic [7:0] oe_n_i,
	input  wire logic [7:0] pu_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] level_o
);
	// outside source lets go while the pull-up is on, so the pin reads high then
	assign level_o = (~oe_n_i & pin_o_i) | (oe_n_i & (pu_i | ext_i));
endmodule // pgp_pin_model

// ---- dv/test_port1_gpio_with_pin_mux.sv ----
`timescale 1ns/1ps
// bench for the port 1 gpio block: random setups checked at the bus and the pins
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_port1_gpio_with_pin_mux;
	import pgp_pkg::*;
	localparam logic [17:0] A_DAT = BYTE_DATA;
	localparam logic [17:0] A_DIR = BYTE_DIR;
	localparam logic [17:0] A_PU  = BYTE_PULLUP;
	localparam logic [17:0] A_FN  = BYTE_FUNC;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [17:0] awaddr = '0, araddr = '0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = 4'h1;
	logic [7:0]  ext = '0;
	logic        pwm = 1'b0, tclk = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, int3, trg, int2, int1;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata;
	logic [7:0]  lvl, pin_o, oe_n, pu_o, dir, lat, pu, fn, rv, xo, xe, xp, xl;
	integer      seed = 32'hEFC99C7F;
	int          bad_count = 0;
	int          tests_run = 0;

	always #2.5 mclk = ~mclk;

	pgp_port1 dut (.MCLK_I(mclk), .RST_N_I(rst_n), .S_AWADDR_I(awaddr), .S_AWVALID_I(awvalid),
		.S_AWREADY_O(awready), .S_WDATA_I(wdata), .S_WSTRB_I(wstrb), .S_WVALID_I(wvalid),
		.S_WREADY_O(wready), .S_BRESP_O(bresp), .S_BVALID_O(bvalid), .S_BREADY_I(1'b1),
		.S_ARADDR_I(araddr), .S_ARVALID_I(arvalid), .S_ARREADY_O(arready), .S_RDATA_O(rdata),
		.S_RRESP_O(rresp), .S_RVALID_O(rvalid), .S_RREADY_I(1'b1), .PIN_I(lvl), .PIN_O(pin_o),
		.PIN_OE_N_O(oe_n), .PULLUP_EN_O(pu_o), .PWM_I(pwm), .TIMER_CLK_OUT_I(tclk),
		.EXT_INT3_O(int3), .TIMER_TRIGGER_O(trg), .EXT_INT2_O(int2), .EXT_INT1_O(int1));

	pgp_pin_model pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .pu_i(pu_o), .ext_i(ext), .level_o(lvl));

	task automatic wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
		logic pa, pd, ta, tw;
		pa = 1'b1;
		pd = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pd)
		begin
			@(negedge mclk);
			ta = pa && awready;
			tw = pd && wready;
			@(posedge mclk);
			if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
			if (tw) begin wvalid <= 1'b0; pd = 1'b0; end
		end
		do @(negedge mclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [17:0] a, output logic [7:0] d, output logic [1:0] r);
		logic t;
		araddr <= a;
		arvalid <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge mclk);
			t = arready;
			@(posedge mclk);
		end
		arvalid <= 1'b0;
		do @(negedge mclk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		@(posedge mclk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#50000;
		bad_count++;
		wrap_up;
	end

	initial
	begin
		ext <= 8'hA5;
		repeat (10) @(posedge mclk);
		#1;
		`CHK("oe_rst", PIN_MASK, oe_n & PIN_MASK)
		`CHK("pu_rst", 8'h00, pu_o & PIN_MASK)
		@(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(A_DIR, rv, rs); `CHK("dir_rd", 8'hFF, rv)
		rd(A_PU, rv, rs); `CHK("pu_rd", 8'h00, rv)
		rd(A_FN, rv, rs); `CHK("fn_rd", 8'h04, rv)
		rd(A_DAT, rv, rs); `CHK("dat_rd", 8'hA1, rv)
		wr(A_DAT + 18'h4, 8'hFF, rs); `CHK("bad_wr", RESP_SLVERR, rs)
		rd(A_DAT + 18'h4, rv, rs); `CHK("bad_rd", RESP_SLVERR, rs)
		// a write with the low byte lane off is answered but must leave the register alone
		wstrb <= 4'h0;
		wr(A_PU, 8'hF1, rs); `CHK("nostrb_wr", RESP_OKAY, rs)
		wstrb <= 4'h1;
		rd(A_PU, rv, rs); `CHK("nostrb_rd", 8'h00, rv)
		for (int i = 0; i < 30; i++)
		begin
			dir = $random(seed);
			lat = $random(seed);
			pu = $random(seed);
			fn = (i < 2) ? {8{i[0]}} : $random(seed);
			ext <= $random(seed);
			pwm <= $random(seed);
			tclk <= $random(seed);
			wr(A_DAT, lat, rs); `CHK("wr_ok", RESP_OKAY, rs)
			wr(A_DIR, dir, rs);
			wr(A_PU, pu, rs);
			wr(A_FN, fn, rs);
			fn = (fn & PIN_MASK) | FUNC_FIXED;
			xe = (~dir | (fn & 8'hE0)) & ~(fn & 8'h11);
			xo = (lat & ~(fn & 8'h11)) | {3'b0, pwm & fn[4], 3'b0, tclk & fn[0]};
			xp = ~dir & pu & PIN_MASK;
			xl = (~xe & xo) | (xe & (xp | ext));
			repeat (6) @(posedge mclk);
			#1;
			`CHK("oe", xe & PIN_MASK, oe_n & PIN_MASK)
			`CHK("pin", xo & ~xe & PIN_MASK, pin_o & ~xe & PIN_MASK)
			`CHK("pull", xp, pu_o & PIN_MASK)
			`CHK("int3", fn[7] ? xl[7] : 1'b1, int3)
			`CHK("trg", fn[7] & xl[7], trg)
			`CHK("int2", fn[6] ? xl[6] : 1'b1, int2)
			`CHK("int1", fn[5] ? xl[5] : 1'b1, int1)
			@(posedge mclk);
			rd(A_DAT, rv, rs); `CHK("dat", ((dir & lat) | (~dir & xl)) & PIN_MASK, rv)
			rd(A_PU, rv, rs); `CHK("pu", pu & PIN_MASK, rv)
			rd(A_FN, rv, rs); `CHK("fn", fn, rv)
			rd(A_DIR, rv, rs); `CHK("dir", 8'hFF, rv)
		end
		wrap_up;
	end
endmodule // test_port1_gpio_with_pin_mux
